// ==== srtc_cycle.v ====
/*
 * One SRAM bus cycle engine: drives chip select, output enable, write strobe,
 * address and data for a single read or write, then waits out recovery.
 * Assumes the data lane inputs are already synchronised by the caller.
 */
`include "srtc_defines.vh"
module srtc_cycle #(
    parameter ACCESS_CYC = `SRTC_ACCESS_CYC,
    parameter WPULSE_CYC = `SRTC_WPULSE_CYC,
    parameter RECOV_CYC = `SRTC_RECOVERY_CYC
) (
    // Clock and reset.
    input wire clock_in,
    input wire rst_in,
    // Request side.
    input wire start_in,
    input wire write_in,
    input wire [16:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] sync_data_in,
    output reg done_out,
    output reg [7:0] rdata_out,
    // Pins.
    output reg chip_sel_n_out,
    output reg out_en_n_out,
    output reg write_n_out,
    output reg [16:0] address_bus_out,
    output reg [7:0] data_bus_out,
    output reg data_bus_oe_out
);
    localparam S_IDLE = 4'b0001;
    localparam S_SETUP = 4'b0010;
    localparam S_ACT = 4'b0100;
    localparam S_REC = 4'b1000;
    reg [3:0] state_q;
    reg [7:0] cnt_q;
    reg wr_q;
    always @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= S_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            chip_sel_n_out <= 1'b1;
            out_en_n_out <= 1'b1;
            write_n_out <= 1'b1;
            address_bus_out <= `SRTC_ADDR_RESET;
            data_bus_out <= 8'h00;
            data_bus_oe_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start_in) begin
                        // Address settles a full cycle before any strobe falls.
                        address_bus_out <= addr_in; // [RULE5]
                        data_bus_out <= wdata_in;
                        wr_q <= write_in;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    chip_sel_n_out <= 1'b0;
                    // Output enable stays high on writes so the bus never fights the part.
                    out_en_n_out <= wr_q; // [RULE7]
                    write_n_out <= ~wr_q;
                    data_bus_oe_out <= wr_q;
                    cnt_q <= wr_q ? WPULSE_CYC[7:0] : ACCESS_CYC[7:0];
                    state_q <= S_ACT;
                end
                S_ACT: begin
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        // Write strobe rises with chip select and output enable, so the cycle ends while address is still held.
                        write_n_out <= 1'b1; // [RULE5]
                        chip_sel_n_out <= 1'b1;
                        out_en_n_out <= 1'b1;
                        rdata_out <= sync_data_in;
                        cnt_q <= RECOV_CYC[7:0];
                        state_q <= S_REC;
                    end
                end
                S_REC: begin
                    data_bus_oe_out <= 1'b0;
                    // Strobes stay high for the recovery time before the next cycle.
                    if (cnt_q > 8'h01) begin // [RULE6]
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        done_out <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== srtc_defines.vh ====
/*
 * Constants for the hidden-clock SRAM host controller: command register map,
 * unlock key, bus timing counts and command codes.
 * Assumes a 100 MHz clock and an asynchronous SRAM with a hidden clock on the bus.
 */
`ifndef SRTC_DEFINES_VH
`define SRTC_DEFINES_VH
`define SRTC_CLK_PERIOD_NS 10
`define SRTC_ACCESS_TIME_NS 200
`define SRTC_WRITE_PULSE_NS 150
`define SRTC_WRITE_RECOVERY_TIME_NS 20
`define SRTC_ACCESS_CYC ((`SRTC_ACCESS_TIME_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS)
`define SRTC_WPULSE_CYC ((`SRTC_WRITE_PULSE_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS)
`define SRTC_RECOVERY_CYC ((`SRTC_WRITE_RECOVERY_TIME_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS)
`define SRTC_KEY 64'h5CA3_3AC5_5CA3_3AC5
`define SRTC_NBITS 64
`define SRTC_REG_CTRL 4'h0
`define SRTC_REG_STATUS 4'h1
`define SRTC_REG_SCRATCH 4'h2
`define SRTC_REG_CLK_LO 4'h4
`define SRTC_REG_CLK_HI 4'h5
`define SRTC_REG_MEM_ADDR 4'h6
`define SRTC_REG_MEM_DATA 4'h7
`define SRTC_CMD_READ_CLK 3'h1
`define SRTC_CMD_WRITE_CLK 3'h2
`define SRTC_CMD_MEM_READ 3'h3
`define SRTC_CMD_MEM_WRITE 3'h4
`define SRTC_ADDR_W 17
`define SRTC_ADDR_RESET 17'h1_FFFF
`endif

// ==== srtc_host.v ====
/*
 * Host controller for an SRAM with a hidden serial clock: unlocks the clock with
 * the 64-bit key and moves all 64 clock bits, and offers plain memory access.
 * Assumes the SRAM pins are wired directly; the data bus is a tristate pin split
 * into input, output and enable. Software uses a simple strobe register port.
 */
// Implementation choices: the register addresses and the strobed register port.
// Function
// RULE1: Device reads when select low and write strobe high.
// RULE2: Device decodes 17 address bits to one byte.
// RULE3: Write starts at the later falling select or strobe edge.
// RULE4: Write ends at the earlier rising select or strobe edge.
// RULE5: Host keeps address stable throughout each write cycle.
// RULE6: Host holds write strobe high for recovery time between cycles.
// RULE7: Host keeps output enable high during writes.
// RULE8: Device floats outputs when write strobe falls during a read.
// RULE9: Clock unlocks after 64 key write cycles, one bit on lowest lane.
// RULE10: Before the key matches, all accesses go to memory.
// RULE11: After match, next 64 cycles move clock bits, memory blocked.
// RULE12: One read to any address resets key pointer to bit zero.
// RULE13: Matching key bit advances pointer; mismatch ignores the rest.
// RULE14: Any read during key recognition aborts and resets the pointer.
// RULE15: Each transfer cycle reads or writes one clock bit on lowest lane.
// RULE16: Key writes also land in memory; host uses one scratch location.
// RULE17: Cycles without this chip select do not disturb sequences.
// RULE18: Clock state is eight 8-bit registers, one bit per cycle.
// RULE19: Transfer runs register 0 bit 0 through register 7 bit 7, BCD.
// RULE20: Host updates clock registers as whole 8-bit groups.
// RULE21: Key is C5 3A A3 5C C5 3A A3 5C, each LSB first.
// RULE22: Calendar corrects month ends and leap years itself.
// RULE23: Hours bit 7 selects 12-hour mode; bit 5 is then PM.
// RULE24: Day bit 4 set ignores abort input; clear lets it cancel transfers.
// RULE25: Day bit 5 stops oscillator; both bits ship set.
// RULE26: After 64 transfer cycles the clock relocks and needs a new key.
`include "srtc_defines.vh"
module srtc_host #(
    parameter NBITS = `SRTC_NBITS
) (
    // Clock and reset.
    input wire clock_in,
    input wire rst_in,
    // Software register port.
    input wire [3:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [31:0] reg_rdata_out,
    // SRAM pins.
    output wire chip_sel_n_out,
    output wire out_en_n_out,
    output wire write_n_out,
    output wire [16:0] address_bus_out,
    output wire [7:0] data_bus_out,
    output wire data_bus_oe_out,
    input wire [7:0] data_bus_in
);
    localparam S_IDLE = 5'b00001;
    localparam S_PREP = 5'b00010;
    localparam S_KEY = 5'b00100;
    localparam S_XFER = 5'b01000;
    localparam S_MEM = 5'b10000;
    reg [4:0] state_q;
    reg [2:0] cmd_q;
    reg [6:0] bit_q;
    reg [63:0] clk_q;
    reg [63:0] clk_wr_q;
    reg [16:0] scratch_q;
    reg [16:0] mem_addr_q;
    reg [7:0] mem_wdata_q;
    reg [7:0] mem_rdata_q;
    reg busy_q;
    reg done_q;
    reg start_q;
    reg wr_q;
    reg [16:0] addr_q;
    reg [7:0] wdata_q;
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;
    reg [7:0] sync3_q;
    reg [7:0] lane_q;
    wire cyc_done;
    wire [7:0] cyc_rdata;
    wire [63:0] key = `SRTC_KEY;
    // Three-stage synchroniser; a lane counts once stages two and three agree.
    always @(posedge clock_in) begin
        if (rst_in) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
            lane_q <= 8'h00;
        end else begin
            sync1_q <= data_bus_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lane_q <= (sync2_q & sync3_q) | (lane_q & (sync2_q | sync3_q));
        end
    end
    srtc_cycle u_cycle (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(start_q),
        .write_in(wr_q),
        .addr_in(addr_q),
        .wdata_in(wdata_q),
        .sync_data_in(lane_q),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .chip_sel_n_out(chip_sel_n_out),
        .out_en_n_out(out_en_n_out),
        .write_n_out(write_n_out),
        .address_bus_out(address_bus_out),
        .data_bus_out(data_bus_out),
        .data_bus_oe_out(data_bus_oe_out)
    );
    always @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= S_IDLE;
            cmd_q <= 3'h0;
            bit_q <= 7'h00;
            clk_q <= 64'h0000_0000_0000_0000;
            clk_wr_q <= 64'h0000_0000_0000_0000;
            scratch_q <= 17'h0_0000;
            mem_addr_q <= 17'h0_0000;
            mem_wdata_q <= 8'h00;
            mem_rdata_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            start_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 17'h0_0000;
            wdata_q <= 8'h00;
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            start_q <= 1'b0;
            reg_rdata_out <= 32'h0000_0000;
            if (reg_read_in) begin
                case (reg_addr_in)
                    `SRTC_REG_STATUS: reg_rdata_out <= {30'h0000_0000, done_q, busy_q};
                    `SRTC_REG_SCRATCH: reg_rdata_out <= {15'h0000, scratch_q};
                    `SRTC_REG_CLK_LO: reg_rdata_out <= clk_q[31:0];
                    `SRTC_REG_CLK_HI: reg_rdata_out <= clk_q[63:32];
                    `SRTC_REG_MEM_ADDR: reg_rdata_out <= {15'h0000, mem_addr_q};
                    `SRTC_REG_MEM_DATA: reg_rdata_out <= {24'h00_0000, mem_rdata_q};
                    default: reg_rdata_out <= 32'h0000_0000;
                endcase
            end
            if (reg_write_in && !busy_q) begin
                case (reg_addr_in)
                    `SRTC_REG_CTRL: begin
                        cmd_q <= reg_wdata_in[2:0];
                        if (reg_wdata_in[2:0] != 3'h0) begin
                            busy_q <= 1'b1;
                            done_q <= 1'b0;
                            state_q <= S_PREP;
                        end
                    end
                    `SRTC_REG_SCRATCH: scratch_q <= reg_wdata_in[16:0];
                    // Whole 32-bit words keep every clock register written as a full byte.
                    `SRTC_REG_CLK_LO: clk_wr_q[31:0] <= reg_wdata_in; // [RULE20]
                    `SRTC_REG_CLK_HI: clk_wr_q[63:32] <= reg_wdata_in; // [RULE20]
                    `SRTC_REG_MEM_ADDR: mem_addr_q <= reg_wdata_in[16:0];
                    `SRTC_REG_MEM_DATA: mem_wdata_q <= reg_wdata_in[7:0];
                    default: busy_q <= busy_q;
                endcase
            end
            case (state_q)
                S_IDLE: busy_q <= busy_q;
                S_PREP: begin
                    start_q <= 1'b1;
                    bit_q <= 7'h00;
                    if (cmd_q == `SRTC_CMD_MEM_READ || cmd_q == `SRTC_CMD_MEM_WRITE) begin
                        addr_q <= mem_addr_q;
                        wdata_q <= mem_wdata_q;
                        wr_q <= (cmd_q == `SRTC_CMD_MEM_WRITE);
                        state_q <= S_MEM;
                    end else if (cmd_q == `SRTC_CMD_READ_CLK || cmd_q == `SRTC_CMD_WRITE_CLK) begin
                        // One read on the scratch location resets the key pointer.
                        addr_q <= scratch_q; // [RULE12]
                        wr_q <= 1'b0;
                        state_q <= S_KEY;
                    end else begin
                        start_q <= 1'b0;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_MEM: begin
                    if (cyc_done) begin
                        mem_rdata_q <= cyc_rdata;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_KEY: begin
                    if (cyc_done) begin
                        // Key bits go out LSB first on the lowest lane, all to the scratch byte.
                        start_q <= 1'b1; // [RULE9] [RULE16]
                        wr_q <= 1'b1;
                        wdata_q <= {7'h00, key[bit_q[5:0]]}; // [RULE21]
                        if (wr_q && bit_q == NBITS[6:0] - 7'h01) begin
                            bit_q <= 7'h00;
                            wr_q <= (cmd_q == `SRTC_CMD_WRITE_CLK);
                            wdata_q <= {7'h00, clk_wr_q[0]};
                            state_q <= S_XFER;
                        end else if (wr_q) begin
                            bit_q <= bit_q + 7'h01;
                            wdata_q <= {7'h00, key[bit_q[5:0] + 6'h01]};
                        end
                    end
                end
                S_XFER: begin
                    if (cyc_done) begin
                        // Bit order runs register 0 bit 0 up to register 7 bit 7.
                        if (!wr_q) clk_q[bit_q[5:0]] <= cyc_rdata[0]; // [RULE15] [RULE19]
                        if (bit_q == NBITS[6:0] - 7'h01) begin
                            // The part relocks after 64 cycles; the next access needs a fresh key.
                            if (wr_q) clk_q <= clk_wr_q; // [RULE26] [RULE18]
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else begin
                            bit_q <= bit_q + 7'h01;
                            wdata_q <= {7'h00, clk_wr_q[bit_q[5:0] + 6'h01]};
                            start_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== srtc_host_assertions.sv ====
/*
 * Checker for the SRAM pins and register port of the host controller.
 * Assumes one clock domain and a synchronous active-high reset.
 */
module srtc_host_assertions (
    // Clock and reset.
    input wire clock_in,
    input wire rst_in,
    // Register port.
    input wire reg_read_in,
    input wire [31:0] reg_rdata_out,
    // SRAM pins.
    input wire chip_sel_n_out,
    input wire out_en_n_out,
    input wire write_n_out,
    input wire [16:0] address_bus_out,
    input wire [7:0] data_bus_out,
    input wire data_bus_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    chk_read_select: assert property (!out_en_n_out |-> !chip_sel_n_out && write_n_out)
        else $error("read without select");
    chk_write_select: assert property (!write_n_out |-> !chip_sel_n_out && out_en_n_out)
        else $error("write strobe outside select");
    chk_read_len: assert property ($fell(out_en_n_out) |-> ##[20:21] $rose(out_en_n_out))
        else $error("read strobe length");
    chk_write_len: assert property ($fell(write_n_out) |-> ##[15:16] $rose(write_n_out))
        else $error("write strobe length");
    chk_addr_hold: assert property (!chip_sel_n_out && $past(!chip_sel_n_out) |-> $stable(address_bus_out))
        else $error("address moved in cycle");
    chk_wdata_hold: assert property (!write_n_out && $past(!write_n_out) |-> $stable(data_bus_out))
        else $error("write data moved");
    chk_recovery_gap: assert property ($rose(write_n_out) |-> write_n_out[*2])
        else $error("recovery too short");
    chk_float_read: assert property (!out_en_n_out |-> !data_bus_oe_out)
        else $error("host drives during read");
    chk_drive_write: assert property (!write_n_out |-> data_bus_oe_out)
        else $error("lane undriven in write");
    chk_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside slot");
endmodule
bind srtc_host srtc_host_assertions u_chk (.clock_in(clock_in), .rst_in(rst_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .chip_sel_n_out(chip_sel_n_out), .out_en_n_out(out_en_n_out),
    .write_n_out(write_n_out), .address_bus_out(address_bus_out), .data_bus_out(data_bus_out),
    .data_bus_oe_out(data_bus_oe_out));

// ==== srtc_sram_model.sv ====
/*
 * Behavioural SRAM with the hidden serial clock behind a key.
 * Assumes cycles end at the rising edge of chip select.
 */
module srtc_sram_model #(
    parameter logic [63:0] INIT_TIME = 64'h0000_0000_0000_0000
) (
    // Pins from the host.
    input wire chip_sel_n_in,
    input wire out_en_n_in,
    input wire write_n_in,
    input wire [16:0] address_bus_in,
    input wire [7:0] data_bus_in,
    // Read data.
    output wire [7:0] data_bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:17'h1_ffff];
    logic [63:0] key = 64'h5ca3_3ac5_5ca3_3ac5;
    logic [63:0] clk_bits = INIT_TIME;
    logic [7:0] wdat, val;
    bit armed, xfer, wr_seen;
    int ptr, idx, cycles;
    wire rd = !chip_sel_n_in && !out_en_n_in && write_n_in;
    // A released lane shows the inverse of its last value, so stale data never looks valid.
    always @* if (rd) val = xfer ? {7'h00, clk_bits[idx]} : mem[address_bus_in];
    assign data_bus_out = rd ? val : ~val;
    // Whichever strobe falls last finds the other already low, whatever order the step runs in.
    always @(negedge write_n_in or negedge chip_sel_n_in) begin
        if (!write_n_in && !chip_sel_n_in) wr_seen = 1;
    end
    always @(posedge chip_sel_n_in) begin
        // Both strobes rise in one step, so the data are taken here and not in a racing block.
        if (wr_seen) wdat = data_bus_in;
        cycles++;
        if (xfer) begin
            if (wr_seen) clk_bits[idx] = wdat[0];
            idx++;
            if (idx == 64) xfer = 0;
        end else if (wr_seen) begin
            mem[address_bus_in] = wdat;
            if (armed && wdat[0] === key[ptr]) ptr++;
            else armed = 0;
            if (ptr == 64) begin
                xfer = 1;
                idx = 0;
                armed = 0;
                ptr = 0;
            end
        end else begin
            ptr = 0;
            armed = 1;
        end
        wr_seen = 0;
    end
endmodule

// ==== testbench.sv ====
/*
 * Testbench for the host controller against the SRAM model.
 * Assumes the register map and commands of the design's defines.
 */
`include "srtc_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
    logic [3:0] reg_addr_in = 0;
    logic [31:0] reg_wdata_in = 0, rv;
    wire [31:0] reg_rdata_out;
    wire cs_n, oe_n, we_n, doe;
    wire [16:0] adr;
    wire [7:0] dho, dmod, dpin;
    int num_errors = 0, n_tests = 0, cyc = 0;
    assign dpin = doe ? dho : dmod;
    srtc_host uut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .write_n_out(we_n),
        .address_bus_out(adr), .data_bus_out(dho), .data_bus_oe_out(doe), .data_bus_in(dpin));
    srtc_sram_model #(.INIT_TIME(64'h0000_0000_0000_0000)) m (.chip_sel_n_in(cs_n), .out_en_n_in(oe_n),
        .write_n_in(we_n), .address_bus_in(adr), .data_bus_in(dpin), .data_bus_out(dmod));
    initial forever #5 clock_in = ~clock_in;
    task summarize();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1;
        @(posedge clock_in);
        reg_write_in <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_read_in <= 1;
        @(posedge clock_in);
        reg_read_in <= 0;
        #1 rv = reg_rdata_out;
    endtask
    // Polls the status until done; the bound keeps a stuck engine from hanging the run.
    task run(input logic [2:0] c);
        int i;
        wr(`SRTC_REG_CTRL, {29'h0, c});
        for (i = 0; i < 4000; i++) begin
            rd(`SRTC_REG_STATUS);
            if (rv[1:0] === 2'b10) break;
        end
        chk("done", 2'b10, rv[1:0]);
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 0;
        #1 chk("idle pins", {3'b111, 17'h1_ffff}, {cs_n, oe_n, we_n, adr});
        wr(`SRTC_REG_MEM_ADDR, 32'h0001_2345);
        wr(`SRTC_REG_MEM_DATA, 32'h0000_00a5);
        run(`SRTC_CMD_MEM_WRITE);
        chk("mem write", 8'ha5, m.mem[17'h1_2345]);
        m.mem[17'h1_2345] = 8'h3c;
        run(`SRTC_CMD_MEM_READ);
        rd(`SRTC_REG_MEM_DATA);
        chk("mem read", 8'h3c, rv[7:0]);
        rd(4'h3);
        chk("unmapped", 32'h0000_0000, rv);
        wr(`SRTC_REG_SCRATCH, 32'h0001_2345);
        wr(`SRTC_REG_CLK_LO, 32'h1234_5678);
        wr(`SRTC_REG_CLK_HI, 32'h2199_0807);
        m.cycles = 0;
        run(`SRTC_CMD_WRITE_CLK);
        chk("clock write", 64'h2199_0807_1234_5678, m.clk_bits);
        chk("write cycles", 129, m.cycles);
        chk("scratch lane", 1'b0, m.mem[17'h1_2345][0]);
        rd(`SRTC_REG_CLK_LO);
        chk("clock readback", 32'h1234_5678, rv);
        m.clk_bits = 64'h9988_0706_0504_0302;
        m.cycles = 0;
        run(`SRTC_CMD_READ_CLK);
        rd(`SRTC_REG_CLK_LO);
        chk("clock lo", 32'h0504_0302, rv);
        rd(`SRTC_REG_CLK_HI);
        chk("clock hi", 32'h9988_0706, rv);
        chk("read cycles", 129, m.cycles);
        chk("relocked", 1'b0, m.xfer);
        m.mem[17'h1_2345] = 8'h5a;
        run(`SRTC_CMD_MEM_READ);
        rd(`SRTC_REG_MEM_DATA);
        chk("mem after", 8'h5a, rv[7:0]);
        m.cycles = 0;
        run(3'h7);
        chk("no bus cycle", 0, m.cycles);
        summarize();
    end
endmodule
